// >>> src/pwr_pkg.sv
// constants, field positions and state type of the automatic power-down unit
// Function
// - memory sleeps unless its inputs change
// - enabled unit counts idle after strobe stops
// - fifteen idle aux periods raise powerdown flag
// - idle entry only when unit enabled
// - power-down blocks bus, deselects memories
// - resumed strobe pulses leave power-down
// - chip select low or reset exits
// - toggling logic inputs keep arrays awake
// - chip select high forces memory standby
// - blocking bits cut signals to arrays
// - full speed default on, bit sets off
// - idle counter keeps aux clock always
// - logic arrays stay active in power-down
// - port pins hold, tri-state, undefined
// - array behaviour depends on full speed
// - full speed control at bit three
// - bit one enables automatic power-down
// - mode registers clear at power-up only
// - chip select high disables memories
package pwr_pkg;

    // ****************************************
    // counter and register layout
    // ****************************************
    localparam int IDLE_W = 4;
    localparam logic [3:0] IDLE_LIMIT = 4'hf;
    localparam logic [3:0] IDLE_RESET = 4'h0;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int ZERO_AUTO_EN = 1;
    localparam int ZERO_SPEED_OFF = 3;
    localparam int ZERO_CLK_ARRAY = 4;
    localparam int ZERO_CLK_MCELL = 5;
    localparam int TWO_CNTL0 = 2;
    localparam int TWO_STROBE = 5;
    localparam int TWO_DBE = 6;
    localparam logic [7:0] ZERO_MASK = 8'h3a;
    localparam logic [7:0] TWO_MASK = 8'h7c;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int CNTL_W = 3;

    // ****************************************
    // state of the top module
    // ****************************************
    typedef struct packed {
        logic [1:0] strobe_sync;
        logic strobe_last;
        logic [1:0] aux_sync;
        logic aux_last;
        logic [1:0] sel_sync;
        logic [1:0] rstpin_sync;
        logic [3:0] idle_count;
        logic powerdown_flag;
        logic [7:0] reg_zero;
        logic [7:0] reg_two;
        logic [15:0] mem_addr;
        logic [7:0] mem_data;
        logic [15:0] la_addr;
        logic [7:0] la_data;
        logic [2:0] la_cntl;
        logic la_strobe;
        logic la_dbe;
        logic la_clk_array;
        logic la_clk_mcell;
    } top_state_t;

endpackage

// >>> src/activity_if.sv
// carrier between a watched input bundle and its change detector
interface activity_if #(parameter int W = 8);
    logic [W-1:0] data;
    logic changed;
    modport src (output data, input changed);
    modport det (input data, output changed);
endinterface

// >>> src/activity_detect.sv
// change detector: one-cycle pulse whenever the watched bundle moves
module activity_detect #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rst,
    activity_if.det act
);
    typedef struct packed {
        logic [W-1:0] last;
        logic changed;
    } act_state_t;

    act_state_t s;
    act_state_t next_s;

    // compare against last sample; reset value zero so first change is seen
    always_comb begin
        next_s = s;
        next_s.last = act.data;
        next_s.changed = (act.data != s.last);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign act.changed = s.changed;
endmodule

// >>> src/auto_powerdown_unit.sv
// automatic power-down unit with memory and logic-array power gating
module auto_powerdown_unit (
    input wire logic clk,
    input wire logic rst,
    input wire logic addr_strobe_input,
    input wire logic aux_clock_input,
    input wire logic chip_sel_n,
    input wire logic reset_input,
    input wire logic reg_zero_wr,
    input wire logic reg_two_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic [15:0] mcu_addr,
    input wire logic [7:0] mcu_data,
    input wire logic [2:0] mcu_cntl,
    input wire logic mcu_dbe,
    input wire logic data_port_oe_req,
    input wire logic periph_oe_req,
    output logic [7:0] power_mode_reg_zero,
    output logic [7:0] power_mode_reg_two,
    output logic powerdown_flag,
    output logic [3:0] idle_count,
    output logic [15:0] mem_addr,
    output logic [7:0] mem_data,
    output logic memory_select,
    output logic memory_standby,
    output logic [15:0] la_addr,
    output logic [7:0] la_data,
    output logic [2:0] la_cntl,
    output logic la_strobe,
    output logic la_dbe,
    output logic la_clk_array,
    output logic la_clk_mcell,
    output logic logic_standby,
    output logic full_speed,
    output logic port_hold,
    output logic addr_out_defined,
    output logic data_port_oe,
    output logic periph_oe
);
    // ****************************************
    // state and decoded conditions
    // ****************************************
    pwr_pkg::top_state_t s;
    pwr_pkg::top_state_t next_s;

    logic strobe_edge;
    logic aux_rise;
    logic auto_en;
    logic speed_off;
    logic exit_level;
    logic mem_sel_now;

    activity_if #(.W(24)) mem_act ();
    activity_if #(.W(32)) la_act ();

    // edges seen only on the second sync stage and its delayed copy
    assign strobe_edge = s.strobe_sync[1] ^ s.strobe_last;
    assign aux_rise = s.aux_sync[1] & ~s.aux_last;
    assign auto_en = s.reg_zero[pwr_pkg::ZERO_AUTO_EN];
    assign speed_off = s.reg_zero[pwr_pkg::ZERO_SPEED_OFF];
    assign exit_level = ~s.sel_sync[1] | s.rstpin_sync[1];
    assign mem_sel_now = ~s.powerdown_flag & ~s.sel_sync[1];

    // ****************************************
    // next-state logic
    // ****************************************
    always_comb begin
        next_s = s;
        // two-flop synchronisers for the strobe, aux clock, chip select and reset pins
        next_s.strobe_sync = {s.strobe_sync[0], addr_strobe_input};
        next_s.strobe_last = s.strobe_sync[1];
        next_s.aux_sync = {s.aux_sync[0], aux_clock_input};
        next_s.aux_last = s.aux_sync[1];
        next_s.sel_sync = {s.sel_sync[0], chip_sel_n};
        next_s.rstpin_sync = {s.rstpin_sync[0], reset_input};

        // mode registers only written, never cleared by reset pin
        if (reg_zero_wr) begin
            next_s.reg_zero = reg_wdata & pwr_pkg::ZERO_MASK;
        end
        if (reg_two_wr) begin
            next_s.reg_two = reg_wdata & pwr_pkg::TWO_MASK;
        end

        // no idle entry while the unit is disabled
        if (!auto_en) begin
            next_s.idle_count = pwr_pkg::IDLE_RESET;
            next_s.powerdown_flag = 1'b0;
        // strobe activity exits and restarts count
        end else if (strobe_edge) begin
            next_s.idle_count = pwr_pkg::IDLE_RESET;
            next_s.powerdown_flag = 1'b0;
        // count aux periods, never gated by blocking bits
        end else if (aux_rise && s.idle_count != pwr_pkg::IDLE_LIMIT) begin
            next_s.idle_count = s.idle_count + 4'h1;
            // fifteenth idle period raises the flag
            if (s.idle_count == pwr_pkg::IDLE_LIMIT - 4'h1) begin
                next_s.powerdown_flag = 1'b1;
            end
        end
        // level exit wins over entry; count left saturated so no re-entry
        if (exit_level) begin
            next_s.powerdown_flag = 1'b0;
        end

        // bus frozen toward memories and arrays while powered down
        if (!s.powerdown_flag) begin
            next_s.mem_addr = mcu_addr;
            next_s.mem_data = mcu_data;
            next_s.la_addr = mcu_addr;
            next_s.la_data = mcu_data;
        end

        // blocking bits hold their array input low
        for (int i = 0; i < pwr_pkg::CNTL_W; i++) begin
            next_s.la_cntl[i] = mcu_cntl[i] & ~s.reg_two[pwr_pkg::TWO_CNTL0 + i];
        end
        next_s.la_strobe = s.strobe_sync[1] & ~s.reg_two[pwr_pkg::TWO_STROBE];
        next_s.la_dbe = mcu_dbe & ~s.reg_two[pwr_pkg::TWO_DBE];
        next_s.la_clk_array = s.aux_sync[1] & ~s.reg_zero[pwr_pkg::ZERO_CLK_ARRAY];
        next_s.la_clk_mcell = s.aux_sync[1] & ~s.reg_zero[pwr_pkg::ZERO_CLK_MCELL];
    end

    // power-up reset clears everything, mode registers included
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    // ****************************************
    // activity detectors
    // ****************************************
    assign mem_act.data = {s.mem_addr, s.mem_data};
    assign la_act.data = {s.la_addr, s.la_data, s.la_cntl, s.la_strobe,
                          s.la_dbe, s.la_clk_array, s.la_clk_mcell, 1'b0};

    activity_detect #(.W(24)) u_mem_act (
        .clk(clk),
        .rst(rst),
        .act(mem_act)
    );

    activity_detect #(.W(32)) u_la_act (
        .clk(clk),
        .rst(rst),
        .act(la_act)
    );

    // ****************************************
    // outputs
    // ****************************************
    assign power_mode_reg_zero = s.reg_zero;
    assign power_mode_reg_two = s.reg_two;
    assign powerdown_flag = s.powerdown_flag;
    assign idle_count = s.idle_count;
    assign mem_addr = s.mem_addr;
    assign mem_data = s.mem_data;
    assign la_addr = s.la_addr;
    assign la_data = s.la_data;
    assign la_cntl = s.la_cntl;
    assign la_strobe = s.la_strobe;
    assign la_dbe = s.la_dbe;
    assign la_clk_array = s.la_clk_array;
    assign la_clk_mcell = s.la_clk_mcell;
    // memories deselected in power-down or when chip deselected
    assign memory_select = mem_sel_now;
    // wake only for one cycle on a change while selected
    assign memory_standby = ~(mem_act.changed & mem_sel_now);
    assign logic_standby = speed_off & ~la_act.changed;
    // full speed is the inverse of bit three
    assign full_speed = ~speed_off;
    // port pins: hold, undefined address, tri-stated data
    assign port_hold = s.powerdown_flag;
    assign addr_out_defined = ~s.powerdown_flag;
    assign data_port_oe = data_port_oe_req & ~s.powerdown_flag;
    assign periph_oe = periph_oe_req & ~s.powerdown_flag;

    // ****************************************
    // assertions and covers
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    AST_IDLE_LIMIT: assert property (
        $rose(s.powerdown_flag) |-> $past(s.idle_count) == 4'he && $past(aux_rise))
        else $error("flag rose without fifteenth idle period");
    AST_IDLE_COUNT: assert property (
        auto_en && !strobe_edge && aux_rise && s.idle_count != 4'hf
        |=> s.idle_count == $past(s.idle_count) + 4'h1)
        else $error("idle counter did not advance");
    AST_DISABLED: assert property (
        !auto_en |=> !s.powerdown_flag && s.idle_count == 4'h0)
        else $error("power-down while unit disabled");
    // deselect checked in the flag's own cycle: an exit may reselect one cycle later
    AST_BUS_FROZEN: assert property (
        s.powerdown_flag |-> !memory_select ##1 ($stable(mem_addr) && $stable(mem_data)))
        else $error("memory bus moved in power-down");
    AST_STROBE_WAKE: assert property (
        auto_en && strobe_edge |=> !s.powerdown_flag && s.idle_count == 4'h0)
        else $error("strobe did not clear power-down");
    AST_LEVEL_EXIT: assert property (
        exit_level |=> !s.powerdown_flag)
        else $error("chip select or reset did not exit power-down");
    AST_MEM_SLEEP_PD: assert property (
        s.powerdown_flag |-> memory_standby)
        else $error("memory awake in power-down");
    AST_DESELECT_STANDBY: assert property (
        s.sel_sync[1] |-> memory_standby && !memory_select)
        else $error("deselected memory awake");
    AST_BLOCK_STROBE: assert property (
        s.reg_two[pwr_pkg::TWO_STROBE] |=> !la_strobe)
        else $error("blocked strobe reached arrays");
    AST_FULL_SPEED: assert property (
        !speed_off |-> full_speed && !logic_standby)
        else $error("array standby while full speed on");
    AST_REG_KEEP: assert property (
        s.rstpin_sync[1] && !reg_zero_wr && !reg_two_wr
        |=> $stable(power_mode_reg_zero) && $stable(power_mode_reg_two))
        else $error("reset pin changed mode registers");
    AST_PORTS_TRI: assert property (
        s.powerdown_flag |-> !data_port_oe && !periph_oe && port_hold)
        else $error("ports driven in power-down");

    COV_ENTER: cover property ($rose(s.powerdown_flag));
    COV_STROBE_EXIT: cover property (s.powerdown_flag ##1 strobe_edge ##1 !s.powerdown_flag);
    COV_SEL_EXIT: cover property (s.powerdown_flag && !s.sel_sync[1]);
endmodule

// >>> tb/mcu_model.sv
// far-side bus master model: address strobe and free-running aux clock
module mcu_model (
    input wire logic clk,
    input wire logic strobe_run,
    output logic addr_strobe_input,
    output logic aux_clock_input
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    logic run_q = 1'b0;
    logic strobe_q = 1'b0;
    logic aux_q = 1'b0;

    // ****************************************
    // pin pacing
    // ****************************************
    // run request taken on the rising edge so it never races the pin update
    always @(posedge clk) begin
        run_q <= strobe_run;
    end

    // aux never stops, period 8 clk, well below 15x strobe rate
    // pins start low; strobe parks at its last level while the bus sleeps
    always @(negedge clk) begin
        cnt <= cnt + 1;
        if (cnt % 4 == 3) begin
            aux_q <= ~aux_q;
        end
        if (run_q && cnt % 2 == 1) begin
            strobe_q <= ~strobe_q;
        end
    end

    assign addr_strobe_input = strobe_q;
    assign aux_clock_input = aux_q;
endmodule

// >>> tb/tb.sv
// self-checking bench of the automatic power-down unit
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, strobe_run, addr_strobe_input, aux_clock_input, chip_sel_n;
    logic reset_input, reg_zero_wr, reg_two_wr, mcu_dbe, data_port_oe_req, periph_oe_req;
    logic [7:0] reg_wdata, mcu_data, power_mode_reg_zero, power_mode_reg_two, mem_data, la_data;
    logic [15:0] mcu_addr, mem_addr, la_addr;
    logic [2:0] mcu_cntl, la_cntl;
    logic [3:0] idle_count;
    logic powerdown_flag, memory_select, memory_standby, la_strobe, la_dbe, la_clk_array;
    logic la_clk_mcell, logic_standby, full_speed, port_hold, addr_out_defined;
    logic data_port_oe, periph_oe;
    int error_cnt = 0;
    int cmp_count = 0;

    auto_powerdown_unit DUT (.clk, .rst, .addr_strobe_input, .aux_clock_input, .chip_sel_n,
        .reset_input, .reg_zero_wr, .reg_two_wr, .reg_wdata, .mcu_addr, .mcu_data, .mcu_cntl,
        .mcu_dbe, .data_port_oe_req, .periph_oe_req, .power_mode_reg_zero, .power_mode_reg_two,
        .powerdown_flag, .idle_count, .mem_addr, .mem_data, .memory_select, .memory_standby,
        .la_addr, .la_data, .la_cntl, .la_strobe, .la_dbe, .la_clk_array, .la_clk_mcell,
        .logic_standby, .full_speed, .port_hold, .addr_out_defined, .data_port_oe, .periph_oe);
    mcu_model mcu (.clk, .strobe_run, .addr_strobe_input, .aux_clock_input);

    // ****************************************
    // clock, tasks, watchdog
    // ****************************************
    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic end_sim;
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk({15'h0000, got}, {15'h0000, exp});
    endtask

    // one-cycle write strobe, readback settles one cycle later
    task automatic wr(input logic two, input logic [7:0] d);
        reg_zero_wr = ~two;
        reg_two_wr = two;
        reg_wdata = d;
        @(negedge clk);
        reg_zero_wr = 1'b0;
        reg_two_wr = 1'b0;
        @(negedge clk);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // bounded wait: a hang shows up as a failed compare
    task automatic wait_flag(input logic exp);
        for (int i = 0; i < 400 && powerdown_flag !== exp; i++) @(negedge clk);
        chk1(powerdown_flag, exp);
    endtask

    // counts the cycles memory leaves standby after one bus move
    task automatic count_wake(input logic [15:0] a, input logic [15:0] exp);
        int k;
        k = 0;
        mcu_addr = a;
        repeat (4) begin
            @(negedge clk);
            k += (memory_standby === 1'b0);
        end
        chk(16'(k), exp);
    endtask

    // long enough for every bounded wait to run out
    initial begin
        #100us;
        error_cnt++;
        end_sim();
    end

    // main sequence, inputs move on the falling edge
    initial begin
        rst = 1'b1; strobe_run = 1'b1; chip_sel_n = 1'b0; reset_input = 1'b0;
        reg_zero_wr = 1'b0; reg_two_wr = 1'b0; reg_wdata = 8'h00; mcu_addr = 16'h1234;
        mcu_data = 8'h5a; mcu_cntl = 3'h7; mcu_dbe = 1'b1;
        data_port_oe_req = 1'b1; periph_oe_req = 1'b1;
        cyc(16);
        rst = 1'b0;
        cyc(4);
        chk(16'(power_mode_reg_zero), 16'h0000);
        chk1(full_speed, 1'b1);
        wr(1'b0, 8'hff);
        chk(16'(power_mode_reg_zero), 16'h003a);
        chk1(full_speed, 1'b0);
        wr(1'b1, 8'hff);
        chk(16'(power_mode_reg_two), 16'h007c);
        cyc(3);
        chk(16'({la_cntl, la_strobe, la_dbe, la_clk_array, la_clk_mcell}), 16'h0000);
        chk1(logic_standby, 1'b1);
        wr(1'b1, 8'h00);
        cyc(2);
        chk(16'(la_cntl), 16'h0007);
        reset_input = 1'b1;
        cyc(4);
        reset_input = 1'b0;
        cyc(4);
        chk(16'(power_mode_reg_zero), 16'h003a);
        wr(1'b0, 8'h30);
        strobe_run = 1'b0;
        chip_sel_n = 1'b1;
        cyc(200);
        chk1(powerdown_flag, 1'b0);
        strobe_run = 1'b1;
        cyc(8);
        strobe_run = 1'b0;
        wr(1'b0, 8'h32);
        for (int i = 0; i < 400 && idle_count !== 4'he; i++) @(negedge clk);
        chk1(powerdown_flag, 1'b0);
        wait_flag(1'b1);
        chk(16'(idle_count), 16'h000f);
        chk(16'({port_hold, addr_out_defined, data_port_oe, periph_oe}), 16'h0008);
        cyc(1);
        chk1(memory_select, 1'b0);
        mcu_addr = 16'hbeef;
        mcu_data = 8'ha5;
        cyc(3);
        chk(mem_addr, 16'h1234);
        chk(la_addr, 16'h1234);
        chk(16'(mem_data), 16'h005a);
        chk(16'(la_data), 16'h005a);
        strobe_run = 1'b1;
        wait_flag(1'b0);
        chk(16'(idle_count), 16'h0000);
        cyc(2);
        chk(mem_addr, 16'hbeef);
        chk(16'(la_data), 16'h00a5);
        strobe_run = 1'b0;
        wait_flag(1'b1);
        chip_sel_n = 1'b0;
        cyc(6);
        chk1(powerdown_flag, 1'b0);
        chip_sel_n = 1'b1;
        strobe_run = 1'b1;
        cyc(8);
        strobe_run = 1'b0;
        wait_flag(1'b1);
        reset_input = 1'b1;
        cyc(6);
        chk1(powerdown_flag, 1'b0);
        reset_input = 1'b0;
        chip_sel_n = 1'b0;
        cyc(8);
        chk1(memory_select, 1'b1);
        count_wake(16'h4321, 16'h0001);
        chip_sel_n = 1'b1;
        cyc(6);
        count_wake(16'h0f0f, 16'h0000);
        end_sim();
    end
endmodule
